// ### port_board_model.sv
// Board side of the pads: cell drive, board drivers, pull-up.
// An undriven pad without pull-up toggles each cycle.
`timescale 1ns/1ps
module port_board_model
    import port_io_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic [NUM_PINS-1:0] padOut,
    input  wire logic [NUM_PINS-1:0] padOeN,
    input  wire logic [NUM_PINS-1:0] pullupEn,
    input  wire logic [NUM_PINS-1:0] extEn,
    input  wire logic [NUM_PINS-1:0] extVal,
    output logic      [NUM_PINS-1:0] padIn
);
    logic [NUM_PINS-1:0] last_ff = '0;
    // Cell drive wins, then the board driver, then the pull-up
    assign padIn = (~padOeN & padOut) | (padOeN & extEn & extVal)
                 | (padOeN & ~extEn & (pullupEn | ~last_ff));
    always_ff @(posedge sys_clk)
        last_ff <= padIn;
endmodule

// ### port_io_assertions.sv
// Checker for pad and crossbar relations of the port block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module port_io_assertions
    import port_io_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                reset,
    input wire logic [7:0]          regAddr,
    input wire logic [7:0]          regWrData,
    input wire logic                regWrite,
    input wire logic [NUM_PINS-1:0] padOut,
    input wire logic [NUM_PINS-1:0] padOeN,
    input wire logic [NUM_PINS-1:0] pullupEn,
    input wire logic [NUM_PINS-1:0] rxEn,
    input wire logic [NUM_FUNC-1:0] funcIn_ff,
    input wire logic [NUM_FUNC-1:0] funcPlaced_ff
);
    logic                     xbarOn_ff;
    logic                     pullOff_ff;
    logic      [31:0]         pushPull_ff;
    wire logic [NUM_PINS-1:0] ppPin = pushPull_ff[NUM_PINS-1:0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Mirror of select 2 and output mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            xbarOn_ff   <= 1'b0;
            pullOff_ff  <= 1'b0;
            pushPull_ff <= {4{RST_OUTPUT_MODE}};
        end else if (regWrite && regAddr == ADDR_XBAR_SEL_2) begin
            xbarOn_ff  <= regWrData[XBAR_ENABLE_BIT];
            pullOff_ff <= regWrData[PULLUP_DISABLE_BIT];
        end else if (regWrite && regAddr[7:2] == ADDR_OUTPUT_MODE_0[7:2]) begin
            pushPull_ff[regAddr[1:0]*8 +: 8] <= regWrData;
        end
    end
    sequence pullOffWr;
        regWrite && regAddr == ADDR_XBAR_SEL_2 && regWrData[PULLUP_DISABLE_BIT];
    endsequence
    sequence quietCycle;
        !regWrite;
    endsequence
    analog_pull_off_a: assert property ((pullupEn & ~rxEn) == '0)
        else $error("analog pin pulled up");
    analog_drive_off_a: assert property ((~padOeN & ~rxEn) == '0)
        else $error("analog pin driven");
    low_drive_pull_a: assert property ((~padOeN & ~padOut & pullupEn) == '0)
        else $error("pull-up on while driving low");
    reset_float_a: assert property (!$past(xbarOn_ff) |-> &padOeN)
        else $error("pin driven before crossbar enable");
    reset_pullup_a: assert property (!$past(xbarOn_ff) && !$past(pullOff_ff) |-> pullupEn == rxEn)
        else $error("pull-up wrong before crossbar enable");
    global_pull_off_a: assert property ($past(pullOff_ff) |-> pullupEn == '0)
        else $error("pull-up on under global disable");
    pull_off_seq_a: assert property (pullOffWr ##1 quietCycle |=> pullupEn == '0)
        else $error("global disable write ignored");
    drain_no_high_a: assert property ((~padOeN & padOut & ~$past(ppPin)) == '0)
        else $error("open-drain pin driven high");
    unplaced_in_a: assert property ((funcIn_ff & ~funcPlaced_ff) == '0)
        else $error("unplaced function reads nonzero");
    xbar_off_func_a: assert property (!$past(xbarOn_ff, 2) && !$past(xbarOn_ff) |-> funcPlaced_ff == '0)
        else $error("function placed with crossbar off");
endmodule

// ### port_io_cell_config.sv
// Port pin configuration registers, priority crossbar and pin cells.
// Assumes a single-cycle register port and synchronous pad and function inputs.
// Overview of operation
// - Each pin's input-mode bit selects analog (0) or digital (1) operation.
// - An analog pin has its pull-up, output driver and input receiver all off.
// - Reading an analog pin always gives zero.
// - After reset all pins float with pull-ups on until the crossbar enable is set.
// - A digital pin with output-mode 1 drives the pad high or low after its output value.
// - Open-drain pins never drive high, pulling low for 0 and floating for 1.
// - A digital pin that is not driving has its weak pull-up on.
// - A pin driving low has its weak pull-up off.
// - The global pull-up disable bit turns all weak pull-ups off.
// - Reading a digital pin gives the sensed pad level, not the driven value.
// - Pin state is always readable through the port data register, whatever the crossbar.
// - A priority crossbar maps selected functions onto pins under three select registers.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module port_io_cell_config
    import port_io_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [7:0]            regRdData_ff,
    input  wire logic [NUM_PINS-1:0]   padIn,
    output logic      [NUM_PINS-1:0]   padOut,
    output logic      [NUM_PINS-1:0]   padOeN,
    output logic      [NUM_PINS-1:0]   pullupEn,
    output logic      [NUM_PINS-1:0]   rxEn,
    input  wire logic [NUM_FUNC-1:0]   funcOut,
    input  wire logic [NUM_FUNC-1:0]   funcDrive,
    output logic      [NUM_FUNC-1:0]   funcIn_ff,
    output logic      [NUM_FUNC-1:0]   funcPlaced_ff
);

    function automatic int pinIndex(input int port, input int bitPos);
        return port * PORT_BITS + bitPos;
    endfunction

    function automatic logic portBitExists(input int port, input int bitPos);
        return (port < NUM_PORTS - 1) || (bitPos < LAST_PORT_PINS);
    endfunction

    logic [7:0] portData_ff   [NUM_PORTS];
    logic [7:0] inputMode_ff  [NUM_PORTS];
    logic [7:0] outputMode_ff [NUM_PORTS];
    logic [7:0] xbarSel0_ff;
    logic [7:0] xbarSel1_ff;
    logic [7:0] xbarSel2_ff;

    logic [NUM_PINS-1:0] latchVec;
    logic [NUM_PINS-1:0] digitalVec;
    logic [NUM_PINS-1:0] pushPullVec;
    logic [NUM_PINS-1:0] skipVec;
    logic [NUM_PINS-1:0] readVec;
    logic [NUM_PINS-1:0] pinOutVal;
    logic [NUM_FUNC-1:0] nxt_funcIn;
    logic [NUM_FUNC-1:0] nxt_funcPlaced;
    logic [7:0]          nxt_rdData;
    logic                crossbarEnable;
    logic                pullupGlobalDisable;
    pin_pad_t            padState [NUM_PINS];

    logic [1:0] addrPort;
    logic       hitData;
    logic       hitInMode;
    logic       hitOutMode;

    assign crossbarEnable      = xbarSel2_ff[XBAR_ENABLE_BIT];
    assign pullupGlobalDisable = xbarSel2_ff[PULLUP_DISABLE_BIT];
    assign addrPort   = regAddr[1:0];
    assign hitData    = (regAddr[7:2] == ADDR_PORT_DATA_0[7:2]);
    assign hitInMode  = (regAddr[7:2] == ADDR_INPUT_MODE_0[7:2]);
    assign hitOutMode = (regAddr[7:2] == ADDR_OUTPUT_MODE_0[7:2]);

    // Flatten per-port registers into per-pin vectors
    genvar gp, gb;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            for (gb = 0; gb < PORT_BITS; gb++) begin : g_bit
                if (portBitExists(gp, gb)) begin : g_pin
                    assign latchVec[pinIndex(gp, gb)]    = portData_ff[gp][gb];
                    assign digitalVec[pinIndex(gp, gb)]  = inputMode_ff[gp][gb];
                    assign pushPullVec[pinIndex(gp, gb)] = outputMode_ff[gp][gb];
                end
            end
        end
    endgenerate

    // Only port 0 pins can be skipped by software; analog pins are skipped always
    assign skipVec = {{(NUM_PINS-PORT_BITS){1'b0}}, xbarSel1_ff};

    // Priority crossbar: enabled function of rank r takes the r-th free pin
    always_comb begin
        logic [4:0] rank;
        logic [4:0] freeIdx;
        logic [4:0] funcRank [NUM_FUNC];
        logic       pinFree;
        rank = 5'd0;
        freeIdx = 5'd0;
        pinFree = 1'b0;
        funcRank = '{default: 5'd0};
        nxt_funcIn = '0;
        nxt_funcPlaced = '0;
        pinOutVal = latchVec;
        for (int k = 0; k < NUM_FUNC; k++) begin
            funcRank[k] = rank;
            if (xbarSel0_ff[k]) begin
                rank = 5'(rank + 5'd1);
            end
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            pinFree = crossbarEnable & digitalVec[i] & ~skipVec[i];
            if (pinFree) begin
                for (int k = 0; k < NUM_FUNC; k++) begin
                    if (xbarSel0_ff[k] && funcRank[k] == freeIdx) begin
                        pinOutVal[i] = funcOut[k] | ~funcDrive[k];
                        nxt_funcIn[k] = readVec[i];
                        nxt_funcPlaced[k] = 1'b1;
                    end
                end
                freeIdx = 5'(freeIdx + 5'd1);
            end
        end
    end

    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_cell
            pin_cfg_t cellCfg;
            assign cellCfg = '{digital: digitalVec[gp], pushPull: pushPullVec[gp],
                               outVal: pinOutVal[gp], xbarEn: crossbarEnable,
                               pullDisable: pullupGlobalDisable};
            port_pin_cell u_cell (
                .sys_clk (sys_clk),
                .reset   (reset),
                .cfg     (cellCfg),
                .padIn   (padIn[gp]),
                .pad_ff  (padState[gp])
            );
            assign padOut[gp]   = padState[gp].drive;
            assign padOeN[gp]   = padState[gp].oeN;
            assign pullupEn[gp] = padState[gp].pullEn;
            assign rxEn[gp]     = padState[gp].rxEn;
            assign readVec[gp]  = padState[gp].readBack;
        end
    endgenerate

    // Read mux: port data reads the pad state, never the latch
    always_comb begin
        logic [31:0] padWord;
        padWord = {{(32-NUM_PINS){1'b0}}, readVec};
        nxt_rdData = 8'h00;
        if (hitData) begin
            nxt_rdData = padWord[8*addrPort +: 8];
        end else if (hitInMode) begin
            nxt_rdData = inputMode_ff[addrPort];
        end else if (hitOutMode) begin
            nxt_rdData = outputMode_ff[addrPort];
        end else if (regAddr == ADDR_XBAR_SEL_0) begin
            nxt_rdData = xbarSel0_ff;
        end else if (regAddr == ADDR_XBAR_SEL_1) begin
            nxt_rdData = xbarSel1_ff;
        end else if (regAddr == ADDR_XBAR_SEL_2) begin
            nxt_rdData = xbarSel2_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                portData_ff[p]   <= RST_PORT_DATA;
                inputMode_ff[p]  <= RST_INPUT_MODE;
                outputMode_ff[p] <= RST_OUTPUT_MODE;
            end
            xbarSel0_ff <= RST_XBAR_SEL;
            xbarSel1_ff <= RST_XBAR_SEL;
            xbarSel2_ff <= RST_XBAR_SEL;
        end else if (regWrite) begin
            if (hitData) begin
                portData_ff[addrPort] <= regWrData;
            end
            if (hitInMode) begin
                inputMode_ff[addrPort] <= regWrData;
            end
            if (hitOutMode) begin
                outputMode_ff[addrPort] <= regWrData;
            end
            if (regAddr == ADDR_XBAR_SEL_0) begin
                xbarSel0_ff <= regWrData;
            end
            if (regAddr == ADDR_XBAR_SEL_1) begin
                xbarSel1_ff <= regWrData;
            end
            if (regAddr == ADDR_XBAR_SEL_2) begin
                xbarSel2_ff <= regWrData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regRdData_ff  <= 8'h00;
            funcIn_ff     <= '0;
            funcPlaced_ff <= '0;
        end else begin
            regRdData_ff  <= regRead ? nxt_rdData : 8'h00;
            funcIn_ff     <= nxt_funcIn;
            funcPlaced_ff <= nxt_funcPlaced;
        end
    end

endmodule

// ### port_io_cell_config_tb_top.sv
// Self-checking bench for the port pin block.
// Drives the register port and a board model at the pads.
`timescale 1ns/1ps
module port_io_cell_config_tb_top
    import port_io_pkg::*;
;
    logic                sys_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic                xe, pd;
    logic [7:0]          regAddr = 8'h00, regWrData = 8'h00, regRdData_ff;
    logic [NUM_PINS-1:0] padIn, padOut, padOeN, pullupEn, rxEn, dig, drv, pul, pad;
    logic [NUM_PINS-1:0] extEn = '0, extVal = '0;
    logic [NUM_FUNC-1:0] funcOut = '0, funcDrive = '0, funcIn_ff, funcPlaced_ff;
    logic [31:0]         seed = 32'h94ad, inM, outM, dat, r, expRd;
    int                  err_count = 0, comparisons = 0;
    initial forever #4 sys_clk = ~sys_clk;
    port_io_cell_config dut_u (.sys_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData_ff, .padIn, .padOut, .padOeN, .pullupEn, .rxEn, .funcOut, .funcDrive,
        .funcIn_ff, .funcPlaced_ff);
    port_board_model brd_u (.sys_clk, .padOut, .padOeN, .pullupEn, .extEn, .extVal, .padIn);
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [NUM_PINS-1:0] got, input logic [NUM_PINS-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regRead  <= 1'b1;
        regAddr  <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(negedge sys_clk);
        chk(regRdData_ff, e);
    endtask
    task automatic settle();
        @(posedge sys_clk);
        regWrite <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge sys_clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chk(padOeN, '1);
        chk(pullupEn, '1);
        chk(rxEn, '1);
        rd(ADDR_INPUT_MODE_0, RST_INPUT_MODE);
        rd(ADDR_OUTPUT_MODE_0, RST_OUTPUT_MODE);
        for (int i = 0; i < 24; i++) begin
            inM  = (i == 0) ? 32'h0 : xs();
            outM = (i == 1) ? 32'hffffffff : xs();
            dat  = xs();
            r    = xs();
            xe   = (i < 2) | r[0];
            pd   = (i > 3) & r[1];
            for (int p = 0; p < NUM_PORTS; p++) begin
                wr(ADDR_INPUT_MODE_0 + p[7:0], inM[p*8 +: 8]);
                wr(ADDR_OUTPUT_MODE_0 + p[7:0], outM[p*8 +: 8]);
                wr(ADDR_PORT_DATA_0 + p[7:0], dat[p*8 +: 8]);
            end
            wr(ADDR_XBAR_SEL_2, {pd, xe, 6'h00});
            dig = inM[NUM_PINS-1:0];
            drv = {NUM_PINS{xe}} & dig & (outM[NUM_PINS-1:0] | ~dat[NUM_PINS-1:0]);
            pul = dig & ~drv & {NUM_PINS{~pd}};
            r = xs();
            extEn  <= r[NUM_PINS-1:0] | ~pul;
            extVal <= r[31:7];
            pad = (drv & dat[NUM_PINS-1:0]) | (~drv & ~(r[NUM_PINS-1:0] | ~pul))
                | (~drv & (r[NUM_PINS-1:0] | ~pul) & r[31:7]);
            expRd = {7'h00, dig & pad};
            settle();
            chk(padOeN, ~drv);
            chk(padOut & drv, dat[NUM_PINS-1:0] & drv);
            chk(pullupEn, pul);
            chk(rxEn, dig);
            for (int p = 0; p < NUM_PORTS; p++)
                rd(ADDR_PORT_DATA_0 + p[7:0], expRd[p*8 +: 8]);
        end
        wr(ADDR_INPUT_MODE_0, 8'hff);
        wr(ADDR_OUTPUT_MODE_0, 8'hff);
        wr(ADDR_XBAR_SEL_1, 8'h01);
        wr(ADDR_XBAR_SEL_0, 8'h03);
        wr(ADDR_XBAR_SEL_2, 8'h40);
        funcDrive <= 8'hff;
        funcOut   <= 8'h02;
        settle();
        chk(funcPlaced_ff, 8'h03);
        chk(padOeN[2:1], 2'b00);
        chk(padOut[2:1], 2'b10);
        chk(funcIn_ff, 8'h02);
        r = xs();
        @(posedge sys_clk);
        funcOut   <= r[7:0];
        funcDrive <= r[15:8];
        settle();
        chk(padOut[2:1], {r[1] | ~r[9], r[0] | ~r[8]});
        chk(funcIn_ff, {6'h00, r[1] | ~r[9], r[0] | ~r[8]});
        rd(ADDR_XBAR_SEL_0, 8'h03);
        rd(ADDR_XBAR_SEL_1, 8'h01);
        rd(ADDR_XBAR_SEL_2, 8'h40);
        rd(8'h20, 8'h00);
        report_and_stop();
    end
endmodule
bind port_io_cell_config port_io_assertions chk_u (.sys_clk, .reset, .regAddr, .regWrData,
    .regWrite, .padOut, .padOeN, .pullupEn, .rxEn, .funcIn_ff, .funcPlaced_ff);

// ### port_io_pkg.sv
// Shared constants and carrier types for the port pin cell block.
// Assumes an 8-bit register port and synchronous pad inputs.
package port_io_pkg;

    localparam int NUM_PINS  = 25;
    localparam int NUM_PORTS = 4;
    localparam int PORT_BITS = 8;
    localparam int NUM_FUNC  = 8;
    localparam int LAST_PORT_PINS = 1;

    localparam logic [7:0] ADDR_PORT_DATA_0  = 8'h00;
    localparam logic [7:0] ADDR_INPUT_MODE_0 = 8'h04;
    localparam logic [7:0] ADDR_OUTPUT_MODE_0 = 8'h08;
    localparam logic [7:0] ADDR_XBAR_SEL_0   = 8'h0c;
    localparam logic [7:0] ADDR_XBAR_SEL_1   = 8'h0d;
    localparam logic [7:0] ADDR_XBAR_SEL_2   = 8'h0e;

    localparam int XBAR_ENABLE_BIT    = 6;
    localparam int PULLUP_DISABLE_BIT = 7;

    localparam logic [7:0] RST_PORT_DATA   = 8'hff;
    localparam logic [7:0] RST_INPUT_MODE  = 8'hff;
    localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
    localparam logic [7:0] RST_XBAR_SEL    = 8'h00;

    typedef struct packed {
        logic digital;
        logic pushPull;
        logic outVal;
        logic xbarEn;
        logic pullDisable;
    } pin_cfg_t;

    typedef struct packed {
        logic drive;
        logic oeN;
        logic pullEn;
        logic rxEn;
        logic readBack;
    } pin_pad_t;

endpackage

// ### port_pin_cell.sv
// One port pin cell: driver, weak pull-up, receiver and read-back.
// Assumes the pad input is synchronous to sys_clk.
`timescale 1ns/1ps
module port_pin_cell
    import port_io_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     reset,
    input  wire pin_cfg_t cfg,
    input  wire logic     padIn,
    output pin_pad_t      pad_ff
);

    logic     drivesLow;
    logic     drivesHigh;
    pin_pad_t nxt_pad;

    // Driver stays off until the crossbar is enabled
    assign drivesLow  = cfg.digital & cfg.xbarEn & ~cfg.outVal;
    assign drivesHigh = cfg.digital & cfg.xbarEn & cfg.pushPull & cfg.outVal;

    assign nxt_pad.drive    = drivesHigh;
    assign nxt_pad.oeN      = ~(drivesLow | drivesHigh);
    assign nxt_pad.pullEn   = cfg.digital & ~cfg.pullDisable & ~drivesLow & ~drivesHigh;
    assign nxt_pad.rxEn     = cfg.digital;
    assign nxt_pad.readBack = cfg.digital & padIn;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_ff <= '{drive: 1'b0, oeN: 1'b1, pullEn: 1'b1, rxEn: 1'b1, readBack: 1'b0};
        end else begin
            pad_ff <= nxt_pad;
        end
    end

endmodule
